// File: port_csr_pkg.sv
package port_csr_pkg;

  // ==========================================================================
  // Register layout
  localparam int unsigned REG_WIDTH      = 16;
  localparam int unsigned CMD_WIDTH      = 4;
  localparam int unsigned BIT_STATUS_ERR = 15;
  localparam int unsigned BIT_CMD_ERR    = 14;
  localparam int unsigned BIT_RX_RING    = 13;
  localparam int unsigned BIT_TX_RING    = 12;
  localparam int unsigned BIT_CMD_DONE   = 11;
  localparam int unsigned BIT_NO_RX_BUF  = 10;
  localparam int unsigned BIT_STATE_CHG  = 8;
  localparam int unsigned BIT_ZERO_HI    = 9;
  localparam int unsigned BIT_SUMMARY    = 7;
  localparam int unsigned BIT_IRQ_EN     = 6;
  localparam int unsigned BIT_SOFT_RST   = 5;
  localparam int unsigned FLAG_HI        = 15;
  localparam int unsigned FLAG_LO        = 8;
  localparam int unsigned NUM_FLAGS      = 8;

  // Byte-write low and high strobes
  localparam int unsigned LANE_LO = 0;
  localparam int unsigned LANE_HI = 1;

  // ==========================================================================
  // Command codes
  localparam logic [3:0] CMD_NOOP      = 4'h0;
  localparam logic [3:0] CMD_POLL      = 4'h8;
  localparam logic [3:0] CMD_LAST_REAL = 4'h8;

  localparam logic [15:0] RESET_WORD   = 16'h0000;
  localparam logic [7:0]  FLAGS_CLEAR  = 8'h00;
  localparam logic [7:0]  FLAG_DONE_ONLY = 8'h08;

  // Operating states reported in the second register
  typedef enum logic [2:0] {
    ST_RESET,
    ST_PRIMARY_LOAD,
    ST_READY,
    ST_RUNNING,
    ST_BUS_HALTED,
    ST_LINK_HALTED,
    ST_FULL_HALTED
  } op_state_t;

endpackage : port_csr_pkg

// File: csr_event_if.sv
`timescale 1ns/10ps
interface csr_event_if;
  import port_csr_pkg::*;
  logic [NUM_FLAGS-1:0] set_req;
  logic                 rbu_armed;
  logic                 poll_seen;
  modport source (output set_req, output rbu_armed, input poll_seen);
  modport sink   (input set_req, input rbu_armed, output poll_seen);
endinterface : csr_event_if

// File: csr_event_gen.sv
`timescale 1ns/10ps
module csr_event_gen
  import port_csr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        soft_reset_i,
  input  wire logic        status_err_i,
  input  wire logic        cmd_fail_i,
  input  wire logic        rx_posted_i,
  input  wire logic        tx_suspend_i,
  input  wire logic        cmd_complete_i,
  input  wire logic [3:0]  cmd_code_i,
  input  wire logic        rx_dropped_i,
  input  wire logic        fatal_err_i,
  input  wire op_state_t   state_i,
  input  wire logic        boot_req_i,
  input  wire logic        load_xfer_i,
  csr_event_if.source      ev
);
  logic rbu_armed;
  logic next_rbu_armed;
  logic fatal_ok;

  // ==========================================================================
  // Event decode
  always_comb begin
    fatal_ok = (state_i == ST_READY) || (state_i == ST_RUNNING) ||
               (state_i == ST_BUS_HALTED) || (state_i == ST_LINK_HALTED);
    ev.set_req = FLAGS_CLEAR;
    ev.set_req[BIT_STATUS_ERR-FLAG_LO] = status_err_i;                              // [RULE5]
    ev.set_req[BIT_CMD_ERR-FLAG_LO]    = cmd_fail_i;                                // [RULE6]
    ev.set_req[BIT_RX_RING-FLAG_LO]    = rx_posted_i;                               // [RULE7]
    ev.set_req[BIT_TX_RING-FLAG_LO]    = tx_suspend_i;                              // [RULE8]
    ev.set_req[BIT_CMD_DONE-FLAG_LO]   = cmd_complete_i && (cmd_code_i != CMD_NOOP); // [RULE9]
    ev.set_req[BIT_NO_RX_BUF-FLAG_LO]  = rx_dropped_i && rbu_armed;                 // [RULE10]
    ev.set_req[BIT_STATE_CHG-FLAG_LO]  = (fatal_err_i && fatal_ok) ||                // [RULE12]
                                         (boot_req_i && state_i != ST_PRIMARY_LOAD) || // [RULE13]
                                         (load_xfer_i && state_i == ST_PRIMARY_LOAD);
    ev.rbu_armed = rbu_armed;
  end

  // Disarm after one report; a poll demand re-arms
  always_comb begin
    next_rbu_armed = rbu_armed;
    if (rx_dropped_i && rbu_armed) begin
      next_rbu_armed = 1'b0;                                                         // [RULE11]
    end
    if (ev.poll_seen) begin
      next_rbu_armed = 1'b1;                                                         // [RULE11]
    end
    if (soft_reset_i) begin
      next_rbu_armed = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rbu_armed <= 1'b1;
    end else begin
      rbu_armed <= next_rbu_armed;
    end
  end
endmodule : csr_event_gen

// File: port_csr0.sv
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Four host command/status registers; this block holds the first one.
// (RULE2) Flags 15..10 and 8 readable; writing one clears, zero leaves.
// (RULE3) Summary bit 7 is read-only; writes ignored.
// (RULE4) Soft reset bit 5 is write-only and reads zero.
// (RULE5) Status error flag sets on internal status error; cleared by host.
// (RULE6) Command error flag sets on function error or bus timeout.
// (RULE7) Receive ring flag sets when messages placed on receive ring.
// (RULE8) Transmit ring flag sets when transmission suspends.
// (RULE9) Done flag sets on each completed command except no-op; here only code 0000 is excepted, reserved codes still set it.
// (RULE10) No-buffer flag sets when a message is dropped for lack of buffer.
// (RULE11) No-buffer flag re-arms only after a poll demand; soft reset also re-arms it here.
// (RULE12) State change flag sets on fatal error into fully halted.
// (RULE13) State change flag sets entering and leaving primary load via boot.
// (RULE14) Current operating state reported for the second register.
// (RULE15) Summary bit is OR of bits 15..8.
// (RULE16) Interrupt enable is host read/write, never touched by device.
// (RULE17) A write toggling interrupt enable does not load the command field.
// (RULE18) Host issues command and enable change in separate writes.
// (RULE19) Soft reset restores power-up state, then done and summary read one; the command field keeps its value here.
// (RULE20) Code 1000 polls rings; receive polled only without a held buffer.
// (RULE21) Reserved command codes act as no-ops.
// (RULE22) Bits 9 and 4 read zero; flags and controls clear at power-up.
// (RULE23) Interrupt request is summary AND enable.
module port_csr0
  import port_csr_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 wr_i,
  input  wire logic [1:0]           byte_en_i,
  input  wire logic [REG_WIDTH-1:0] wdata_i,
  input  wire logic                 status_err_i,
  input  wire logic                 cmd_fail_i,
  input  wire logic                 rx_posted_i,
  input  wire logic                 tx_suspend_i,
  input  wire logic                 cmd_complete_i,
  input  wire logic                 rx_dropped_i,
  input  wire logic                 fatal_err_i,
  input  wire logic                 boot_req_i,
  input  wire logic                 load_xfer_i,
  input  wire logic                 rx_buf_held_i,
  input  wire logic                 status_read_clear_i,
  output logic [REG_WIDTH-1:0]      rdata_o,
  output logic                      irq_o,
  output logic [CMD_WIDTH-1:0]      cmd_code_o,
  output logic                      cmd_valid_o,
  output logic                      poll_tx_o,
  output logic                      poll_rx_o,
  output logic                      soft_reset_o,
  output op_state_t                 state_o
);

  // ==========================================================================
  // State
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] next_flags;
  logic                 irq_enable_bit;
  logic                 next_irq_enable_bit;
  logic [CMD_WIDTH-1:0] cmd;
  logic [CMD_WIDTH-1:0] next_cmd;
  logic                 cmd_valid;
  logic                 next_cmd_valid;
  logic                 poll_tx;
  logic                 next_poll_tx;
  logic                 poll_rx;
  logic                 next_poll_rx;
  logic                 soft_rst;
  logic                 next_soft_rst;
  logic                 post_reset;
  logic                 next_post_reset;
  op_state_t            state;
  op_state_t            next_state;
  logic [REG_WIDTH-1:0] rdata;
  logic [REG_WIDTH-1:0] next_rdata;
  logic                 irq;
  logic                 next_irq;
  logic                 irq_summary;
  logic                 lo_wr;
  logic                 hi_wr;
  logic                 en_toggle;
  logic                 cmd_take;

  csr_event_if ev ();

  csr_event_gen u_events (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .soft_reset_i   (soft_rst),
    .status_err_i   (status_err_i),
    .cmd_fail_i     (cmd_fail_i),
    .rx_posted_i    (rx_posted_i),
    .tx_suspend_i   (tx_suspend_i),
    .cmd_complete_i (cmd_complete_i),
    .cmd_code_i     (cmd),
    .rx_dropped_i   (rx_dropped_i),
    .fatal_err_i    (fatal_err_i),
    .state_i        (state),
    .boot_req_i     (boot_req_i),
    .load_xfer_i    (load_xfer_i),
    .ev             (ev.source)
  );

  // Real codes only; reserved ones degrade to no-op
  function automatic logic [CMD_WIDTH-1:0] decode_cmd(input logic [CMD_WIDTH-1:0] code);
    if ((code > CMD_LAST_REAL) || (code[2:1] == 2'b11)) begin
      decode_cmd = CMD_NOOP;                                                         // [RULE21]
    end else begin
      decode_cmd = code;
    end
  endfunction : decode_cmd

  // ==========================================================================
  // Write decode
  always_comb begin
    lo_wr       = wr_i && byte_en_i[LANE_LO];
    hi_wr       = wr_i && byte_en_i[LANE_HI];
    irq_summary = |flags;                                                            // [RULE15]
    en_toggle   = lo_wr && (wdata_i[BIT_IRQ_EN] != irq_enable_bit);                  // [RULE17]
    cmd_take    = lo_wr && !en_toggle;                                               // [RULE17]
  end

  // ==========================================================================
  // Flags: set wins over write-one-clear
  always_comb begin
    next_flags = flags;
    if (hi_wr) begin
      for (int i = 0; i < NUM_FLAGS; i++) begin
        if (wdata_i[FLAG_LO + i] && (i != BIT_STATUS_ERR - FLAG_LO)) begin
          next_flags[i] = 1'b0;                                                      // [RULE2]
        end
      end
    end
    if (status_read_clear_i) begin
      next_flags[BIT_STATUS_ERR-FLAG_LO] = 1'b0;                                     // [RULE5]
    end
    if (hi_wr && wdata_i[BIT_STATUS_ERR]) begin
      next_flags[BIT_STATUS_ERR-FLAG_LO] = 1'b0;                                     // [RULE2]
    end
    next_flags = next_flags | ev.set_req;
    next_flags[BIT_ZERO_HI-FLAG_LO] = 1'b0;                                          // [RULE22]
    if (soft_rst) begin
      next_flags = FLAG_DONE_ONLY;                                                   // [RULE19]
    end
  end

  // ==========================================================================
  // Controls and command
  always_comb begin
    next_irq_enable_bit = irq_enable_bit;
    next_cmd            = cmd;
    next_cmd_valid      = 1'b0;
    next_poll_tx        = 1'b0;
    next_poll_rx        = 1'b0;
    next_soft_rst       = lo_wr && wdata_i[BIT_SOFT_RST];                            // [RULE19]
    next_post_reset     = soft_rst;
    ev.poll_seen        = 1'b0;
    if (lo_wr) begin
      next_irq_enable_bit = wdata_i[BIT_IRQ_EN];                                     // [RULE16]
    end
    if (cmd_take && !wdata_i[BIT_SOFT_RST]) begin
      next_cmd       = wdata_i[CMD_WIDTH-1:0];
      next_cmd_valid = decode_cmd(wdata_i[CMD_WIDTH-1:0]) != CMD_NOOP;               // [RULE21]
      if (decode_cmd(wdata_i[CMD_WIDTH-1:0]) == CMD_POLL) begin
        next_poll_tx = 1'b1;                                                         // [RULE20]
        next_poll_rx = !rx_buf_held_i;                                               // [RULE20]
        ev.poll_seen = 1'b1;                                                         // [RULE11]
      end
    end
    if (soft_rst) begin
      next_irq_enable_bit = 1'b0;
      next_cmd_valid      = 1'b0;
    end
  end

  // ==========================================================================
  // Operating state
  always_comb begin
    next_state = state;
    case (state)
      ST_PRIMARY_LOAD: begin
        if (load_xfer_i) begin
          next_state = ST_READY;                                                     // [RULE13]
        end
      end
      ST_RESET, ST_FULL_HALTED: begin
        if (boot_req_i) begin
          next_state = ST_PRIMARY_LOAD;
        end else if (state == ST_RESET) begin
          next_state = ST_READY;
        end
      end
      default: begin
        if (fatal_err_i) begin
          next_state = ST_FULL_HALTED;                                               // [RULE12]
        end else if (boot_req_i) begin
          next_state = ST_PRIMARY_LOAD;                                              // [RULE13]
        end
      end
    endcase
    if (soft_rst) begin
      next_state = ST_RESET;
    end
  end

  // ==========================================================================
  // Read image and interrupt
  always_comb begin
    next_rdata = RESET_WORD;
    next_rdata[FLAG_HI:FLAG_LO] = next_flags;                                        // [RULE2]
    next_rdata[BIT_SUMMARY]     = |next_flags;                                       // [RULE3] [RULE15]
    next_rdata[BIT_IRQ_EN]      = next_irq_enable_bit;                               // [RULE16]
    next_rdata[BIT_SOFT_RST]    = 1'b0;                                              // [RULE4]
    next_rdata[CMD_WIDTH-1:0]   = next_cmd;
    next_irq = (|next_flags) && next_irq_enable_bit;                                 // [RULE23]
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags          <= FLAGS_CLEAR;                                                 // [RULE22]
      irq_enable_bit <= 1'b0;
      cmd            <= '0;
      cmd_valid      <= 1'b0;
      poll_tx        <= 1'b0;
      poll_rx        <= 1'b0;
      soft_rst       <= 1'b0;
      post_reset     <= 1'b0;
      state          <= ST_RESET;
      rdata          <= RESET_WORD;
      irq            <= 1'b0;
    end else begin
      flags          <= next_flags;
      irq_enable_bit <= next_irq_enable_bit;
      cmd            <= next_cmd;
      cmd_valid      <= next_cmd_valid;
      poll_tx        <= next_poll_tx;
      poll_rx        <= next_poll_rx;
      soft_rst       <= next_soft_rst;
      post_reset     <= next_post_reset;
      state          <= next_state;
      rdata          <= next_rdata;
      irq            <= next_irq;
    end
  end

  // Outputs straight from flops; state feeds second register [RULE14]
  assign rdata_o      = rdata;                                                       // [RULE1]
  assign irq_o        = irq;
  assign cmd_code_o   = cmd;
  assign cmd_valid_o  = cmd_valid;
  assign poll_tx_o    = poll_tx;
  assign poll_rx_o    = poll_rx;
  assign soft_reset_o = soft_rst;
  assign state_o      = state;

endmodule : port_csr0

// File: port_csr0_monitor.sv
`timescale 1ns/10ps
module port_csr0_monitor
  import port_csr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        wr_i,
  input  wire logic [1:0]  byte_en_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        status_err_i,
  input  wire logic        cmd_fail_i,
  input  wire logic        rx_posted_i,
  input  wire logic        tx_suspend_i,
  input  wire logic        cmd_complete_i,
  input  wire logic [15:0] rdata_o,
  input  wire logic        irq_o,
  input  wire logic [3:0]  cmd_code_o,
  input  wire logic        cmd_valid_o,
  input  wire logic        poll_tx_o,
  input  wire logic        poll_rx_o,
  input  wire logic        soft_reset_o
);
  // ==========================================================================
  // Register image checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_summary_or: assert property (rdata_o[7] == |rdata_o[15:8])
    else $error("summary bit differs from flag OR");
  a_fixed_zero: assert property (!rdata_o[9] && !rdata_o[4])
    else $error("fixed zero bit reads one");
  a_reset_bit_zero: assert property (!rdata_o[5])
    else $error("soft reset bit reads one");
  a_irq_level: assert property (irq_o == (rdata_o[7] && rdata_o[6]))
    else $error("irq differs from summary and enable");
  a_ring_clear: assert property (wr_i && byte_en_i[1] && wdata_i[13] && !rx_posted_i |=> !rdata_o[13])
    else $error("receive ring flag not cleared");
  a_status_set: assert property (status_err_i |=> rdata_o[15])
    else $error("status error flag not set");
  a_cmd_err_set: assert property (cmd_fail_i |=> rdata_o[14])
    else $error("command error flag not set");
  a_rx_set: assert property (rx_posted_i |=> rdata_o[13])
    else $error("receive ring flag not set");
  a_tx_set: assert property (tx_suspend_i |=> rdata_o[12])
    else $error("transmit ring flag not set");
  a_done_set: assert property (cmd_complete_i && cmd_code_o != 4'h0 |=> rdata_o[11])
    else $error("done flag not set");
  a_enable_kept: assert property (!(wr_i && byte_en_i[0]) && !soft_reset_o |=> $stable(rdata_o[6]))
    else $error("enable changed without host write");
  // Toggle and command in one word would race the command engine
  a_toggle_blocks: assert property (wr_i && byte_en_i[0] && wdata_i[6] != rdata_o[6]
    |=> !cmd_valid_o && $stable(cmd_code_o))
    else $error("command taken on enable toggle");
  a_soft_reset_seq: assert property (wr_i && byte_en_i[0] && wdata_i[5]
    |=> soft_reset_o ##1 rdata_o == 16'h0880)
    else $error("soft reset sequence wrong");
  a_poll_pair: assert property (poll_rx_o |-> poll_tx_o && cmd_code_o == 4'h8)
    else $error("receive poll without poll demand");

  c_poll: cover property (cmd_valid_o && poll_rx_o);
  c_soft: cover property (soft_reset_o);
  c_irq: cover property (irq_o);
endmodule : port_csr0_monitor

bind port_csr0 port_csr0_monitor i_port_csr0_monitor (.*);

// File: host_port_drv.sv
`timescale 1ns/10ps
module host_port_drv (
  input  wire logic        clk_i,
  output logic             wr_o,
  output logic [1:0]       be_o,
  output logic [15:0]      wd_o
);
  initial begin
    wr_o = 1'b0;
    be_o = 2'h0;
    wd_o = 16'h0000;
  end
  // One word per access; callers may put an enable change and a command in one word
  task automatic put(input logic [1:0] be, input logic [15:0] wd);
    @(posedge clk_i);
    wr_o <= 1'b1;
    be_o <= be;
    wd_o <= wd;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Released bus must not look like the last word
    be_o <= ~be;
    wd_o <= ~wd;
  endtask : put
endmodule : host_port_drv

// File: tb_port_csr0.sv
`timescale 1ns/10ps
module tb_port_csr0;
  import port_csr_pkg::*;
  typedef struct packed {
    int unsigned due;
    logic [27:0] m;
    logic [27:0] e;
  } note_t;
  localparam logic [27:0] ALL = 28'hFFFFFFF;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        wr_i, cmd_valid_o, poll_tx_o, poll_rx_o, soft_reset_o, irq_o;
  logic [1:0]  byte_en_i;
  logic [15:0] wdata_i, rdata_o;
  logic [8:0]  ev_v = 9'h000;
  logic        status_err_i, cmd_fail_i, rx_posted_i, tx_suspend_i, cmd_complete_i;
  logic        rx_dropped_i, fatal_err_i, boot_req_i, load_xfer_i;
  logic        rx_buf_held_i = 1'b0;
  logic        status_read_clear_i = 1'b0;
  logic [3:0]  cmd_code_o;
  op_state_t   state_o;
  logic [27:0] obs;
  note_t       q[$];
  note_t       n;
  int unsigned cyc = 0;
  int          fails = 0;
  int          n_compared = 0;
  integer      seed = 32'h5E38DCB7;
  logic [7:0]  r;
  logic [3:0]  f;

  assign {status_err_i, cmd_fail_i, rx_posted_i, tx_suspend_i, cmd_complete_i,
          rx_dropped_i, fatal_err_i, boot_req_i, load_xfer_i} = ev_v;
  assign obs = {cmd_code_o, rdata_o, state_o, irq_o, cmd_valid_o, poll_tx_o, poll_rx_o, soft_reset_o};
  always #2.5 clk_i = ~clk_i;
  // Cycle count moves off the sampling edge so notes and watcher agree
  always @(negedge clk_i) cyc++;

  port_csr0 i_port_csr0 (.*);
  host_port_drv i_host_port_drv (.clk_i(clk_i), .wr_o(wr_i), .be_o(byte_en_i), .wd_o(wdata_i));

  // ==========================================================================
  // Notes and watcher
  task automatic chk(input int unsigned d, input logic [27:0] m, input logic [27:0] e);
    q.push_back('{cyc + d, m, e});
  endtask : chk
  task automatic ck(input logic [15:0] rd, input op_state_t s, input logic [4:0] p);
    chk(1, ALL, {rd[3:0], rd, s, p});
  endtask : ck
  task automatic ev(input logic [8:0] v);
    @(posedge clk_i);
    ev_v <= v;
    @(posedge clk_i);
    ev_v <= 9'h000;
  endtask : ev
  always @(posedge clk_i) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      n = q.pop_front();
      n_compared++;
      if (((obs ^ n.e) & n.m) !== 28'h0000000) begin
        fails++;
        $display("mismatch outputs exp %h seen %h", n.e & n.m, obs & n.m);
      end
    end
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  initial begin
    #10000;
    fails++;
    complete_run();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    chk(2, ALL, {4'h0, 16'h0000, ST_READY, 5'h00});
    $display("test reset done");
    repeat (4) begin
      r = 8'($random(seed));
      f = r[3:0] & ~r[7:4];
      ev({r[3:0], 5'h00});
      ck({r[3:0], 4'h0, |r[3:0], 7'h00}, ST_READY, 5'h00);
      i_host_port_drv.put(2'b10, {r[7:4], 12'h000});
      ck({f, 4'h0, |f, 7'h00}, ST_READY, 5'h00);
      i_host_port_drv.put(2'b10, 16'hF000);
    end
    i_host_port_drv.put(2'b11, 16'h0290);
    ck(16'h0000, ST_READY, 5'h00);
    ev(9'h100);
    ck(16'h8080, ST_READY, 5'h00);
    @(posedge clk_i);
    status_read_clear_i <= 1'b1;
    @(posedge clk_i);
    status_read_clear_i <= 1'b0;
    ck(16'h0000, ST_READY, 5'h00);
    $display("test flags done");
    ev(9'h008);
    ck(16'h0480, ST_READY, 5'h00);
    i_host_port_drv.put(2'b10, 16'h0400);
    ev(9'h008);
    ck(16'h0000, ST_READY, 5'h00);
    i_host_port_drv.put(2'b01, 16'h0040);
    ck(16'h0040, ST_READY, 5'h00);
    i_host_port_drv.put(2'b01, 16'h0048);
    ck(16'h0048, ST_READY, 5'b01110);
    ev(9'h008);
    ck(16'h04C8, ST_READY, 5'b10000);
    rx_buf_held_i <= 1'b1;
    i_host_port_drv.put(2'b01, 16'h0048);
    ck(16'h04C8, ST_READY, 5'b11100);
    i_host_port_drv.put(2'b10, 16'h0400);
    ev(9'h010);
    ck(16'h08C8, ST_READY, 5'b10000);
    i_host_port_drv.put(2'b01, 16'h0001);
    ck(16'h0888, ST_READY, 5'h00);
    i_host_port_drv.put(2'b10, 16'h0800);
    $display("test poll done");
    for (int c = 15; c >= 0; c--) begin
      i_host_port_drv.put(2'b01, 16'(c));
      ck(16'(c), ST_READY, {1'b0, (c inside {[1:5], 8}), (c == 8), 2'b00});
    end
    ev(9'h010);
    ck(16'h0000, ST_READY, 5'h00);
    $display("test codes done");
    ev(9'h004);
    ck(16'h0180, ST_FULL_HALTED, 5'h00);
    i_host_port_drv.put(2'b10, 16'h0100);
    ev(9'h002);
    ck(16'h0180, ST_PRIMARY_LOAD, 5'h00);
    i_host_port_drv.put(2'b10, 16'h0100);
    ev(9'h001);
    ck(16'h0180, ST_READY, 5'h00);
    $display("test states done");
    i_host_port_drv.put(2'b01, 16'h0020);
    chk(1, 28'h0000001, 28'h0000001);
    chk(2, ALL, {4'h0, 16'h0880, ST_RESET, 5'h00});
    repeat (4) @(posedge clk_i);
    $display("test soft reset done");
    complete_run();
  end
endmodule : tb_port_csr0
